// ### hw/srp_pkg.sv
// srp_pkg: constants for the refresh and power-state block of a mobile ddr sdram.
// assumes one clock at 100 MHz and commands sampled on its rising edge.
package srp_pkg;
	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int CLK_PERIOD_PS                = 10000;
	localparam int REFRESH_CYCLE_TIME_PS        = 72000;
	localparam int SELF_REFRESH_EXIT_TIME_PS    = 112500;
	localparam int POWER_DOWN_EXIT_TIME_PS      = 10000;
	localparam int SELF_REFRESH_INTERVAL_CYC    = 780;
	localparam int REFRESH_CYCLE_CYC            = (REFRESH_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SELF_REFRESH_EXIT_CYC_RAW    = (SELF_REFRESH_EXIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SELF_REFRESH_EXIT_CYC        = (SELF_REFRESH_EXIT_CYC_RAW < 2) ? 2 : SELF_REFRESH_EXIT_CYC_RAW;
	localparam int POWER_DOWN_EXIT_CYC          = (POWER_DOWN_EXIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W                        = 16;
	localparam int NUM_BANKS                    = 4;
	localparam int BANK_W                       = 2;
	localparam int ROW_W                        = 13;
	localparam int A10_BIT                      = 10;
	// ************************************************************
	// command codes {cs_n, ras_n, cas_n, we_n}
	// ************************************************************
	localparam logic [3:0] CMD_NOP              = 4'h7;
	localparam logic [3:0] CMD_ACTIVE           = 4'h3;
	localparam logic [3:0] CMD_PRECHARGE        = 4'h2;
	localparam logic [3:0] CMD_REFRESH          = 4'h1;
	localparam logic [3:0] CMD_DEEP_SLEEP       = 4'h6;
	localparam logic [3:0] CMD_DESELECT_MASK    = 4'h8;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_AUTO_REFRESH,
		ST_SELF_REFRESH,
		ST_SELF_EXIT,
		ST_POWER_DOWN,
		ST_PD_EXIT,
		ST_DEEP_SLEEP,
		ST_NEED_INIT
	} srp_state_t;
endpackage

// ### hw/srp_core.sv
// srp_core: device-side state tracking for refresh, self refresh, power-down and deep sleep.
// assumes the controller keeps its timing obligations; inputs are synchronous to clk.
//
// Contract
// R01: controller sends only nop or inhibit until refresh_cycle_time after refresh.
// R02: controller keeps cke high throughout the auto refresh period.
// R03: all banks idle before refresh; precharge-all with a10 high.
// R04: refresh code with cke low enters self refresh; other inputs ignored.
// R05: self refresh keeps data by internal timer, no external clock needed.
// R06: controller idles all banks before self refresh entry.
// R07: controller holds cke low to stay in self refresh.
// R08: self refresh exit: stable clock, cke high, nop for self_refresh_exit_time.
// R09: controller never uses self refresh instead of scheduled auto refresh.
// R10: cke registered low enters precharge or active power-down by bank state.
// R11: in power-down all inputs except cke are ignored, buffers off.
// R12: cke high with nop or deselect exits power-down; nop until power_down_exit_time.
// R13: controller never enters power-down during a burst.
// R14: controller leaves power-down in time to meet refresh needs.
// R15: controller idles banks, quiets bus, meets precharge_time before deep sleep.
// R16: cke low with cs_n, we_n low, ras_n, cas_n high enters deep sleep.
// R17: deep sleep loses data; exit by cke high and nop, then full init.
// R18: clock frequency changes only while all timings stay met.
// R19: all pending operations finish before the clock stops.
// R20: during clock stop cke high, ck low, ck_n high.
// R21: after clock restart one cycle and a nop before valid commands.
// R22: data, mask and strobe stay high impedance during refresh and precharge.
// R23: each auto refresh is one command; row from internal counter.
// R24: precharge with a10 high closes all banks, else the addressed bank.
// R25: controller tracks open rows to check idle preconditions.
`timescale 1ns/10ps
`default_nettype none
module srp_core
	import srp_pkg::*;
#(
	parameter int N_BANKS = srp_pkg::NUM_BANKS,
	parameter int N_ROWS_W = srp_pkg::ROW_W
) (
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire logic                    cke,
	input  wire logic                    cs_n,
	input  wire logic                    ras_n,
	input  wire logic                    cas_n,
	input  wire logic                    we_n,
	input  wire logic [srp_pkg::BANK_W-1:0] ba,
	input  wire logic [srp_pkg::ROW_W-1:0]  addr,
	output logic                         dq_oe_n,
	output logic                         input_buf_en,
	output logic                         array_powered,
	output logic                         data_valid,
	output logic                         precharge_pd,
	output logic                         active_pd,
	output logic                         self_refresh,
	output logic                         deep_sleep,
	output logic                         refresh_busy,
	output logic                         refresh_pulse,
	output logic [srp_pkg::ROW_W-1:0]    refresh_row
);
	import srp_pkg::*;

	// the refresh length check below counts eight busy cycles literally
	if (N_BANKS != 4 || N_BANKS != (1 << BANK_W) || N_ROWS_W != ROW_W || REFRESH_CYCLE_CYC != 8) begin : g_bad_setup
		$error("srp_core: unsupported geometry or refresh timing");
	end

	function automatic logic is_idle_cmd(input logic [3:0] c);
		is_idle_cmd = c[3] || (c == CMD_NOP);
	endfunction

	// ************************************************************
	// state and counters
	// ************************************************************
	srp_state_t             state_reg;
	logic [CNT_W-1:0]       timer_reg;
	logic [CNT_W-1:0]       sr_tick_reg;
	logic [N_BANKS-1:0]     open_reg;
	logic [ROW_W-1:0]       row_reg;
	logic                   cke_reg;
	logic                   data_ok_reg;
	logic                   pulse_reg;
	logic [3:0]             cmd;
	logic                   bus_on;

	assign cmd    = {cs_n, ras_n, cas_n, we_n};
	// ignoring all but cke while low-power or busy states hold
	assign bus_on = (state_reg == ST_IDLE) || (state_reg == ST_NEED_INIT); // R04 R11

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cke_reg <= 1'b1;
		end else begin
			cke_reg <= cke;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			timer_reg <= '0;
		end else begin
			case (state_reg)
			ST_IDLE, ST_NEED_INIT: begin
				if (!cke && cke_reg && !cs_n && cmd == CMD_DEEP_SLEEP) begin
					state_reg <= ST_DEEP_SLEEP; // R16
				end else if (!cke && cke_reg && cmd == CMD_REFRESH && open_reg == '0) begin
					state_reg <= ST_SELF_REFRESH; // R04 R05
				end else if (!cke && cke_reg) begin
					state_reg <= ST_POWER_DOWN; // R10
				end else if (cke && cmd == CMD_REFRESH && state_reg == ST_IDLE) begin
					state_reg <= ST_AUTO_REFRESH; // R23
					timer_reg <= CNT_W'(REFRESH_CYCLE_CYC - 1); // R01
				end
			end
			ST_AUTO_REFRESH: begin
				if (timer_reg == '0) begin
					state_reg <= ST_IDLE;
				end else begin
					timer_reg <= timer_reg - 1'b1;
				end
			end
			ST_SELF_REFRESH: begin
				if (cke) begin
					state_reg <= ST_SELF_EXIT; // R08
					timer_reg <= CNT_W'(SELF_REFRESH_EXIT_CYC - 1);
				end
			end
			ST_SELF_EXIT: begin
				if (timer_reg == '0) begin
					state_reg <= ST_IDLE;
				end else begin
					timer_reg <= timer_reg - 1'b1;
				end
			end
			ST_POWER_DOWN: begin
				if (cke && is_idle_cmd(cmd)) begin
					state_reg <= ST_PD_EXIT; // R12
					timer_reg <= CNT_W'(POWER_DOWN_EXIT_CYC - 1);
				end
			end
			ST_PD_EXIT: begin
				if (timer_reg == '0) begin
					state_reg <= ST_IDLE;
				end else begin
					timer_reg <= timer_reg - 1'b1;
				end
			end
			ST_DEEP_SLEEP: begin
				if (cke && is_idle_cmd(cmd)) begin
					state_reg <= ST_NEED_INIT; // R17
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	// ************************************************************
	// bank tracking
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!resetn) begin
			open_reg <= '0;
		end else if (state_reg == ST_DEEP_SLEEP) begin
			open_reg <= '0;
		end else if (bus_on && cke && cmd == CMD_ACTIVE) begin
			open_reg[ba] <= 1'b1;
		end else if (bus_on && cke && cmd == CMD_PRECHARGE) begin
			if (addr[A10_BIT]) begin
				open_reg <= '0; // R24
			end else begin
				open_reg[ba] <= 1'b0; // R24
			end
		end
	end

	// ************************************************************
	// internal refresh row counter and self refresh timer
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sr_tick_reg <= '0;
		end else if (state_reg == ST_SELF_REFRESH && sr_tick_reg != CNT_W'(SELF_REFRESH_INTERVAL_CYC - 1)) begin
			sr_tick_reg <= sr_tick_reg + 1'b1; // R05
		end else begin
			sr_tick_reg <= '0;
		end
	end

	// model clock runs here; a real part uses its own oscillator in self refresh
	always_ff @(posedge clk) begin
		if (!resetn) begin
			row_reg   <= '0;
			pulse_reg <= 1'b0;
		end else if ((state_reg == ST_IDLE && cke && cmd == CMD_REFRESH)
		             || (state_reg == ST_SELF_REFRESH && sr_tick_reg == CNT_W'(SELF_REFRESH_INTERVAL_CYC - 1))) begin
			row_reg   <= row_reg + 1'b1; // R23
			pulse_reg <= 1'b1;
		end else begin
			pulse_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			data_ok_reg <= 1'b0;
		end else if (state_reg == ST_DEEP_SLEEP) begin
			data_ok_reg <= 1'b0; // R17
		end else if (state_reg == ST_IDLE) begin
			data_ok_reg <= 1'b1;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign dq_oe_n       = 1'b1; // R22
	assign input_buf_en  = (state_reg != ST_POWER_DOWN) && (state_reg != ST_SELF_REFRESH)
	                       && (state_reg != ST_DEEP_SLEEP); // R11
	assign array_powered = (state_reg != ST_DEEP_SLEEP);
	assign data_valid    = data_ok_reg;
	assign precharge_pd  = (state_reg == ST_POWER_DOWN) && (open_reg == '0); // R10
	assign active_pd     = (state_reg == ST_POWER_DOWN) && (open_reg != '0); // R10
	assign self_refresh  = (state_reg == ST_SELF_REFRESH);
	assign deep_sleep    = (state_reg == ST_DEEP_SLEEP);
	assign refresh_busy  = (state_reg == ST_AUTO_REFRESH);
	assign refresh_pulse = pulse_reg;
	assign refresh_row   = row_reg;

	// ************************************************************
	// checks
	// ************************************************************
	a_refresh_len: assert property (@(posedge clk) disable iff (!resetn)
		$rose(refresh_busy) |-> refresh_busy [*8] ##1 !refresh_busy)
		else $error("refresh period length wrong"); // R01
	a_sr_entry: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == ST_IDLE && cke_reg && !cke && cmd == CMD_REFRESH && open_reg == '0) |=> self_refresh)
		else $error("self refresh not entered"); // R04
	a_sr_hold: assert property (@(posedge clk) disable iff (!resetn)
		(self_refresh && !cke) |=> self_refresh)
		else $error("self refresh left with cke low"); // R04
	a_pd_kind: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == ST_POWER_DOWN) |-> (precharge_pd != active_pd))
		else $error("power-down kind inconsistent"); // R10
	a_pd_bufs: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == ST_POWER_DOWN) |-> !input_buf_en)
		else $error("buffers on in power-down"); // R11
	a_pd_exit: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == ST_POWER_DOWN && cke && is_idle_cmd(cmd)) |=> ##[0:3] (state_reg == ST_IDLE))
		else $error("power-down exit late"); // R12
	a_dpd_entry: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == ST_IDLE && cke_reg && !cke && cmd == CMD_DEEP_SLEEP) |=> deep_sleep ##1 !data_valid)
		else $error("deep sleep entry wrong"); // R16 R17
	a_dq_hiz: assert property (@(posedge clk) disable iff (!resetn)
		refresh_busy |-> dq_oe_n)
		else $error("data bus driven in refresh"); // R22
	a_pre_all: assert property (@(posedge clk) disable iff (!resetn)
		(bus_on && cke && cmd == CMD_PRECHARGE && addr[A10_BIT] && !deep_sleep) |=> (open_reg == '0))
		else $error("precharge all left a bank open"); // R24
	a_row_step: assert property (@(posedge clk) disable iff (!resetn)
		refresh_pulse |-> (refresh_row == $past(refresh_row) + 1'b1))
		else $error("refresh row did not advance"); // R23
endmodule
`default_nettype wire

// ### test/srp_ctrl_model.sv
// srp_ctrl_model: behavioural memory controller for cke and the command bus.
// assumes its tasks are called from one bench process and clk runs freely.
`timescale 1ns/10ps
`default_nettype none
module srp_ctrl_model
	import srp_pkg::*;
(
	input  wire logic                    clk,
	output logic                         cke,
	output logic                         cs_n,
	output logic                         ras_n,
	output logic                         cas_n,
	output logic                         we_n,
	output logic [srp_pkg::BANK_W-1:0]   ba,
	output logic [srp_pkg::ROW_W-1:0]    addr
);
	// ****************
	// command driving
	// ****************
	initial begin
		cke = 1'h1;
		{cs_n, ras_n, cas_n, we_n} = CMD_NOP;
		ba = 2'h0;
		addr = 13'h0000;
	end
	// one command for one cycle, changed just after the edge
	task automatic send(input logic [3:0] c, input logic k, input logic [ROW_W-1:0] a, input logic [BANK_W-1:0] b);
		@(posedge clk);
		cke <= k;
		{cs_n, ras_n, cas_n, we_n} <= c;
		addr <= a;
		ba <= b;
	endtask
	// nop cycles; address keeps moving so a stale value never looks held
	task automatic idle(input int n, input logic k);
		repeat (n) begin
			@(posedge clk);
			cke <= k;
			{cs_n, ras_n, cas_n, we_n} <= CMD_NOP;
			addr <= ~addr;
			ba <= ~ba;
		end
	endtask
endmodule
`default_nettype wire

// ### test/tb_sdram_refresh_power_states.sv
// tb_sdram_refresh_power_states: self-checking bench for srp_core.
// assumes srp_ctrl_model drives the pins; times follow the package constants.
`timescale 1ns/10ps
`default_nettype none
module tb_sdram_refresh_power_states;
	import srp_pkg::*;
	logic             clk = 1'h0;
	logic             resetn = 1'h0;
	logic             clk_run = 1'h1;
	wire logic        cke, cs_n, ras_n, cas_n, we_n;
	wire logic [1:0]  ba;
	wire logic [12:0] addr, refresh_row;
	wire logic        dq_oe_n, input_buf_en, array_powered, data_valid, precharge_pd;
	wire logic        active_pd, self_refresh, deep_sleep, refresh_busy, refresh_pulse;
	int               mismatches = 0;
	int               checked = 0;
	logic [12:0]      row_seen;
	// fixed frequency; a stop parks the clock low
	always #5 if (clk_run || clk) clk = ~clk;
	srp_ctrl_model u_ctrl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .ba(ba), .addr(addr));
	srp_core u_dut (.clk(clk), .resetn(resetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_oe_n(dq_oe_n),
		.input_buf_en(input_buf_en), .array_powered(array_powered), .data_valid(data_valid),
		.precharge_pd(precharge_pd), .active_pd(active_pd), .self_refresh(self_refresh),
		.deep_sleep(deep_sleep), .refresh_busy(refresh_busy), .refresh_pulse(refresh_pulse),
		.refresh_row(refresh_row));
	// ****************
	// helpers
	// ****************
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// nops, then look once the edge has landed
	task automatic step(input int n, input logic k);
		u_ctrl.idle(n, k);
		#1;
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// enter power-down from idle, try a refresh there, leave again
	task automatic pd_cycle(input logic act);
		row_seen = refresh_row;
		u_ctrl.send(CMD_NOP, 1'h0, 13'h0000, 2'h0);
		step(1, 1'h0);
		chk(precharge_pd, !act);
		chk(active_pd, act);
		chk(input_buf_en, 1'h0);
		u_ctrl.send(CMD_REFRESH, 1'h0, 13'h1fff, 2'h3);
		step(3, 1'h0);
		chk(refresh_row, row_seen);
		u_ctrl.send(CMD_NOP, 1'h1, 13'h0000, 2'h0);
		step(1, 1'h1);
		chk(precharge_pd | active_pd, 1'h0);
		step(2, 1'h1);
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_reset();
		step(2, 1'h1);
		chk(refresh_row, 13'h0000);
		chk({data_valid, dq_oe_n, input_buf_en, array_powered}, 4'hf);
		chk({self_refresh, deep_sleep, refresh_busy, precharge_pd}, 4'h0);
		$display("reset test done");
	endtask
	task automatic t_refresh();
		row_seen = refresh_row;
		u_ctrl.send(CMD_REFRESH, 1'h1, 13'h1fff, 2'h3);
		step(1, 1'h1);
		chk(refresh_busy, 1'h1);
		chk(refresh_pulse, 1'h1);
		chk(refresh_row, row_seen + 13'h0001);
		chk(dq_oe_n, 1'h1);
		step(1, 1'h1);
		chk(refresh_pulse, 1'h0);
		step(6, 1'h1);
		chk(refresh_busy, 1'h1);
		step(1, 1'h1);
		chk(refresh_busy, 1'h0);
		$display("refresh test done");
	endtask
	task automatic t_power_down();
		pd_cycle(1'h0);
		u_ctrl.send(CMD_ACTIVE, 1'h1, 13'h0123, 2'h1);
		step(1, 1'h1);
		pd_cycle(1'h1);
		u_ctrl.send(CMD_PRECHARGE, 1'h1, 13'h0000, 2'h2);
		step(1, 1'h1);
		pd_cycle(1'h1);
		u_ctrl.send(CMD_PRECHARGE, 1'h1, 13'h0400, 2'h2);
		step(1, 1'h1);
		pd_cycle(1'h0);
		$display("power-down test done");
	endtask
	// clock parked low with cke high, restarted with one nop before a command
	task automatic t_clock_stop();
		step(2, 1'h1);
		clk_run = 1'h0;
		#100;
		chk({clk, cke, input_buf_en}, 3'h3);
		clk_run = 1'h1;
		step(1, 1'h1);
		chk({refresh_busy, self_refresh, precharge_pd, input_buf_en}, 4'h1);
		t_refresh();
		$display("clock stop test done");
	endtask
	task automatic t_self();
		u_ctrl.send(CMD_REFRESH, 1'h0, 13'h0000, 2'h0);
		step(1, 1'h0);
		chk({self_refresh, input_buf_en}, 2'h2);
		row_seen = refresh_row;
		u_ctrl.send(CMD_ACTIVE, 1'h0, 13'h0055, 2'h1);
		step(800, 1'h0);
		chk(refresh_row != row_seen, 1'h1);
		chk(self_refresh, 1'h1);
		u_ctrl.send(CMD_NOP, 1'h1, 13'h0000, 2'h0);
		step(1, 1'h1);
		chk(self_refresh, 1'h0);
		step(12, 1'h1);
		t_refresh();
		pd_cycle(1'h0);
		$display("self refresh test done");
	endtask
	// long stall in deep sleep; no init follows, so it runs last
	task automatic t_deep();
		u_ctrl.send(CMD_DEEP_SLEEP, 1'h0, 13'h0000, 2'h0);
		step(1, 1'h0);
		chk({deep_sleep, array_powered}, 2'h2);
		step(20, 1'h0);
		chk({deep_sleep, data_valid}, 2'h2);
		u_ctrl.send(CMD_NOP, 1'h1, 13'h0000, 2'h0);
		step(2, 1'h1);
		chk({deep_sleep, data_valid}, 2'h0);
		u_ctrl.send(CMD_REFRESH, 1'h1, 13'h0000, 2'h0);
		step(1, 1'h1);
		chk(refresh_busy, 1'h0);
		$display("deep sleep test done");
	endtask
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		t_reset();
		t_refresh();
		t_refresh();
		t_power_down();
		t_clock_stop();
		t_self();
		t_deep();
		conclude();
	end
	// whole run is near 960 cycles; over twelve times that means a hang
	initial begin
		#120000;
		mismatches++;
		conclude();
	end
endmodule
`default_nettype wire
